/* File: hdl/pdrs_defines.vh */
// Register offsets, field positions and reset values of the port data register set.
`ifndef PDRS_DEFINES_VH
`define PDRS_DEFINES_VH

// Register index map on the processor register port.
`define PDRS_ADDR_W 4
`define PDRS_OFS_PIN_INPUT_LEVEL 4'h0
`define PDRS_OFS_OUTPUT_DATA_LATCH 4'h1
`define PDRS_OFS_DIRECTION 4'h2
`define PDRS_OFS_CONTROL 4'h3
`define PDRS_OFS_PIN_DRIVE_SELECT 4'h4
`define PDRS_OFS_OUTPUT_CELL_FLOPS 4'h5
`define PDRS_OFS_OUTPUT_CELL_LOAD_MASK 4'h6
`define PDRS_OFS_INPUT_CELL_OUTPUTS 4'h7
`define PDRS_OFS_DRIVER_ENABLE_STATUS 4'h8
`define PDRS_OFS_PORT_MODE 4'h9

// Field positions inside the port mode register.
`define PDRS_MODE_CELL_ROUTE_BIT 0
`define PDRS_MODE_PERIPH_BIT 1
`define PDRS_MODE_W 2

// Reset values.
`define PDRS_RST_BYTE 8'h00
`define PDRS_RST_MODE 2'h0
`define PDRS_RDATA_UNMAPPED 8'h00

`endif

/* File: hdl/pdrs_sync.v */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module pdrs_sync #(
    parameter WIDTH = 8
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_level
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;
    integer k;

    // Stage one is read only by stage two, so a metastable value never reaches the compare.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
            stage3_reg <= {WIDTH{1'b0}};
            o_level <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            for (k = 0; k < WIDTH; k = k + 1) begin
                if (stage2_reg[k] == stage3_reg[k]) begin
                    o_level[k] <= stage3_reg[k];
                end
            end
        end
    end

endmodule // pdrs_sync

`default_nettype wire

/* File: hdl/pdrs_port.v */
// One general-purpose port: pin sampling, output latch, logic cells, drive control and register port.
//
// Behaviour
// - Pin input register reads return the present (synchronised) pin level.
// - Output data latch stores processor writes and reads them back.
// - Latch bit drives its pin when direction bit or logic-array enable is 1.
// - Output cell flops are addressable and reads return their present outputs.
// - Processor writes load every output cell flop whose mask bit is clear.
// - Each load-mask bit guards one output cell flop; mask is separate register.
// - A set mask bit blocks processor loads of its flop; others still load.
// - All load-mask bits reset to 0, leaving every cell flop writable.
// - Load-mask register is writable and reads back its stored contents.
// - Input cells latch or register pins and feed the logic-array input bus.
// - Input cell outputs are readable through a read-only register.
// - Driver enable status reads 1 for each pin actively driven.
// - Driver enable status reads 0 for each tri-stated pin.
// - First two ports: low nibble drive bits select fast slew, high nibble open drain.
// - Shared cell groups are routable between neighbouring ports.
// - First two ports feed pin inputs into the logic array through input cells.
// - First two ports can output latched low address byte, nibble by nibble.
// - Peripheral I/O mode exists only on the first port in the larger package.
// - Direction 1 means output, 0 input; effective direction ORs the logic-array enable.
// - Control bit 0 selects processor I/O, 1 selects latched address output.
// - Drive bit 1 on an open-drain pin selects open drain; default is push-pull.
// - Fourth port uses only bits 2 and 1, whose drive bits select fast slew.
`timescale 1ns/1ps
`default_nettype none
`include "pdrs_defines.vh"

module pdrs_port #(
    parameter IMPL_MASK = 8'hFF,
    parameter OPEN_DRAIN_MASK = 8'hF0,
    parameter FAST_SLEW_MASK = 8'h0F,
    parameter HAS_ADDR_OUT = 1,
    parameter HAS_CELLS = 1,
    parameter HAS_PERIPH = 0
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [`PDRS_ADDR_W-1:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    output reg o_reg_rvalid,
    input wire [7:0] i_pin_in,
    output reg [7:0] o_pin_out,
    output reg [7:0] o_pin_oe,
    output reg [7:0] o_fast_slew,
    input wire [7:0] i_logic_oe,
    input wire [7:0] i_logic_out_sel,
    input wire [7:0] i_cell_d,
    input wire [7:0] i_cell_load,
    input wire [7:0] i_neighbour_cell_q,
    output reg [7:0] o_output_logic_cell_q,
    input wire [7:0] i_input_cell_gate,
    input wire [7:0] i_input_cell_latch_mode,
    output reg [7:0] o_input_logic_cell_q,
    input wire i_addr_strobe,
    input wire [7:0] i_addr_low,
    input wire [7:0] i_periph_data,
    input wire [7:0] i_periph_oe
);

    localparam [7:0] IMPL = IMPL_MASK;
    localparam [7:0] OD_PINS = OPEN_DRAIN_MASK;
    localparam [7:0] SLEW_PINS = FAST_SLEW_MASK;
    localparam [7:0] CELL_BITS = (HAS_CELLS != 0) ? IMPL : 8'h00;
    localparam [7:0] CTRL_BITS = (HAS_ADDR_OUT != 0) ? IMPL : 8'h00;

    reg [7:0] out_latch_reg;
    reg [7:0] direction_reg;
    reg [7:0] control_reg;
    reg [7:0] drive_reg;
    reg [7:0] cell_q_reg;
    reg [7:0] cell_mask_reg;
    reg [7:0] input_cell_reg;
    reg [7:0] addr_latch_reg;
    reg [`PDRS_MODE_W-1:0] mode_reg;
    reg [7:0] cell_q_next;
    reg [7:0] input_cell_next;
    reg [7:0] pin_out_next;
    reg [7:0] pin_oe_next;
    reg [7:0] rdata_next;
    reg [7:0] drive_level;
    reg [7:0] enable_level;
    wire [7:0] pin_level;
    wire [7:0] cell_source;
    wire periph_on;

    // Masks a written byte to the bits this port really has.
    function [7:0] pdrs_keep;
        input [7:0] value;
        input [7:0] keep;
        begin
            pdrs_keep = value & keep;
        end
    endfunction

    // True when a write strobe targets the given register index.
    function pdrs_hit;
        input wr;
        input [`PDRS_ADDR_W-1:0] addr;
        input [`PDRS_ADDR_W-1:0] ofs;
        begin
            pdrs_hit = wr && (addr == ofs);
        end
    endfunction

    pdrs_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_pin_in),
        .o_level(pin_level)
    );

    assign cell_source = mode_reg[`PDRS_MODE_CELL_ROUTE_BIT] ? i_neighbour_cell_q : cell_q_reg;

    assign periph_on = (HAS_PERIPH != 0) && mode_reg[`PDRS_MODE_PERIPH_BIT];

    // Processor-writable configuration and data registers.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_latch_reg <= `PDRS_RST_BYTE;
            direction_reg <= `PDRS_RST_BYTE;
            control_reg <= `PDRS_RST_BYTE;
            drive_reg <= `PDRS_RST_BYTE;
            cell_mask_reg <= `PDRS_RST_BYTE;
            mode_reg <= `PDRS_RST_MODE;
        end else begin
            if (pdrs_hit(i_reg_wr, i_reg_addr, `PDRS_OFS_OUTPUT_DATA_LATCH)) begin
                out_latch_reg <= pdrs_keep(i_reg_wdata, IMPL);
            end
            if (pdrs_hit(i_reg_wr, i_reg_addr, `PDRS_OFS_DIRECTION)) begin
                direction_reg <= pdrs_keep(i_reg_wdata, IMPL);
            end
            if (pdrs_hit(i_reg_wr, i_reg_addr, `PDRS_OFS_CONTROL)) begin
                control_reg <= pdrs_keep(i_reg_wdata, CTRL_BITS);
            end
            if (pdrs_hit(i_reg_wr, i_reg_addr, `PDRS_OFS_PIN_DRIVE_SELECT)) begin
                drive_reg <= pdrs_keep(i_reg_wdata, IMPL & (OD_PINS | SLEW_PINS));
            end
            if (pdrs_hit(i_reg_wr, i_reg_addr, `PDRS_OFS_OUTPUT_CELL_LOAD_MASK)) begin
                cell_mask_reg <= pdrs_keep(i_reg_wdata, CELL_BITS);
            end
            if (pdrs_hit(i_reg_wr, i_reg_addr, `PDRS_OFS_PORT_MODE)) begin
                mode_reg[`PDRS_MODE_CELL_ROUTE_BIT] <= (HAS_CELLS != 0) && i_reg_wdata[`PDRS_MODE_CELL_ROUTE_BIT];
                mode_reg[`PDRS_MODE_PERIPH_BIT] <= (HAS_PERIPH != 0) && i_reg_wdata[`PDRS_MODE_PERIPH_BIT];
            end
        end
    end

    // Output cell next state: the logic array loads first, a processor write overrides unmasked bits.
    always @* begin : cell_next_p
        integer b;
        b = 0;
        cell_q_next = cell_q_reg;
        for (b = 0; b < 8; b = b + 1) begin
            if (i_cell_load[b]) begin
                cell_q_next[b] = i_cell_d[b];
            end
            if (pdrs_hit(i_reg_wr, i_reg_addr, `PDRS_OFS_OUTPUT_CELL_FLOPS) && !cell_mask_reg[b]) begin
                cell_q_next[b] = i_reg_wdata[b];
            end
        end
        cell_q_next = pdrs_keep(cell_q_next, CELL_BITS);
    end

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cell_q_reg <= `PDRS_RST_BYTE;
        end else begin
            cell_q_reg <= cell_q_next;
        end
    end

    // Input cells take the pin level while the gate is 1 and hold it while the gate is 0, in latch and register mode alike.
    always @* begin : in_cell_p
        integer b;
        b = 0;
        input_cell_next = input_cell_reg;
        for (b = 0; b < 8; b = b + 1) begin
            if (i_input_cell_gate[b]) begin
                input_cell_next[b] = pin_level[b];
            end else if (i_input_cell_latch_mode[b]) begin
                input_cell_next[b] = input_cell_reg[b];
            end
        end
        input_cell_next = pdrs_keep(input_cell_next, CELL_BITS);
    end

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            input_cell_reg <= `PDRS_RST_BYTE;
        end else begin
            input_cell_reg <= input_cell_next;
        end
    end

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            addr_latch_reg <= `PDRS_RST_BYTE;
        end else if (i_addr_strobe) begin
            addr_latch_reg <= i_addr_low;
        end
    end

    // Pin data and enable selection.  The driver is one cycle behind its sources, a trade
    // made so every pin output leaves a flip-flop and never glitches.
    always @* begin : pin_sel_p
        integer b;
        b = 0;
        drive_level = 8'h00;
        enable_level = 8'h00;
        for (b = 0; b < 8; b = b + 1) begin
            if (periph_on) begin
                drive_level[b] = i_periph_data[b];
                enable_level[b] = i_periph_oe[b];
            end else if (control_reg[b]) begin
                drive_level[b] = addr_latch_reg[b];
                enable_level[b] = direction_reg[b] | i_logic_oe[b];
            end else if (i_logic_out_sel[b] && (HAS_CELLS != 0)) begin
                drive_level[b] = cell_source[b];
                enable_level[b] = direction_reg[b] | i_logic_oe[b];
            end else begin
                drive_level[b] = out_latch_reg[b];
                enable_level[b] = direction_reg[b] | i_logic_oe[b];
            end
        end
        drive_level = pdrs_keep(drive_level, IMPL);
        enable_level = pdrs_keep(enable_level, IMPL);
    end

    // Open drain turns a driven high into release, so only lows are actively driven.
    always @* begin : open_drain_p
        integer b;
        b = 0;
        pin_out_next = drive_level;
        pin_oe_next = enable_level;
        for (b = 0; b < 8; b = b + 1) begin
            if (drive_reg[b] && OD_PINS[b]) begin
                pin_out_next[b] = 1'b0;
                pin_oe_next[b] = enable_level[b] & ~drive_level[b];
            end
        end
    end

    // Registered pin drivers, slew control and logic-array facing outputs.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pin_out <= 8'h00;
            o_pin_oe <= 8'h00;
            o_fast_slew <= 8'h00;
            o_output_logic_cell_q <= 8'h00;
            o_input_logic_cell_q <= 8'h00;
        end else begin
            o_pin_out <= pin_out_next;
            o_pin_oe <= pin_oe_next;
            o_fast_slew <= drive_reg & SLEW_PINS & IMPL;
            o_output_logic_cell_q <= cell_q_next;
            o_input_logic_cell_q <= input_cell_next;
        end
    end

    // Read multiplexer; unmapped indices and missing registers read zero.
    always @* begin
        case (i_reg_addr)
            `PDRS_OFS_PIN_INPUT_LEVEL: rdata_next = pdrs_keep(pin_level, IMPL);
            `PDRS_OFS_OUTPUT_DATA_LATCH: rdata_next = out_latch_reg;
            `PDRS_OFS_DIRECTION: rdata_next = direction_reg;
            `PDRS_OFS_CONTROL: rdata_next = control_reg;
            `PDRS_OFS_PIN_DRIVE_SELECT: rdata_next = drive_reg;
            `PDRS_OFS_OUTPUT_CELL_FLOPS: rdata_next = cell_q_reg;
            `PDRS_OFS_OUTPUT_CELL_LOAD_MASK: rdata_next = cell_mask_reg;
            `PDRS_OFS_INPUT_CELL_OUTPUTS: rdata_next = input_cell_reg;
            `PDRS_OFS_DRIVER_ENABLE_STATUS: rdata_next = pdrs_keep(o_pin_oe, IMPL);
            `PDRS_OFS_PORT_MODE: rdata_next = {6'h00, mode_reg};
            default: rdata_next = `PDRS_RDATA_UNMAPPED;
        endcase
    end

    // Read data is presented one cycle after the read strobe and held until the next read.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_next;
            end
        end
    end

endmodule // pdrs_port

`default_nettype wire

/* File: bench/pdrs_port_sva.sv */
// Concurrent checks on the register port, load mask and cells of one port.
`timescale 1ns/1ps
`default_nettype none
`include "pdrs_defines.vh"
module pdrs_port_sva (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [`PDRS_ADDR_W-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic [7:0] i_pin_in,
    input wire logic [7:0] o_pin_oe,
    input wire logic [7:0] i_cell_load,
    input wire logic [7:0] o_output_logic_cell_q
);
    logic [7:0] mask_reg;
    // Shadow of the load mask; it lets cell loads be judged bit by bit.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mask_reg <= 8'h00;
        end else if (i_reg_wr && i_reg_addr == `PDRS_OFS_OUTPUT_CELL_LOAD_MASK) begin
            mask_reg <= i_reg_wdata;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence cell_wr_s;
        i_reg_wr && i_reg_addr == `PDRS_OFS_OUTPUT_CELL_FLOPS && i_cell_load == 8'h00;
    endsequence
    sequence pin_read_s;
        $stable(i_pin_in)[*8] ##0 (i_reg_rd && i_reg_addr == `PDRS_OFS_PIN_INPUT_LEVEL);
    endsequence
    read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read got no answer");
    read_quiet_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("answer without read");
    unmapped_zero_a: assert property (i_reg_rd && i_reg_addr > 4'h9 |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    cell_load_a: assert property (cell_wr_s |=> ((o_output_logic_cell_q ^ $past(i_reg_wdata)) & ~mask_reg) == 8'h00)
        else $error("unmasked cell not loaded");
    cell_hold_a: assert property (cell_wr_s |=> ((o_output_logic_cell_q ^ $past(o_output_logic_cell_q)) & mask_reg) == 8'h00)
        else $error("masked cell changed");
    mask_read_a: assert property (i_reg_rd && i_reg_addr == `PDRS_OFS_OUTPUT_CELL_LOAD_MASK |=> o_reg_rdata == $past(mask_reg))
        else $error("mask readback wrong");
    pin_level_a: assert property (pin_read_s |=> o_reg_rdata == $past(i_pin_in))
        else $error("pin level readback wrong");
    oe_status_a: assert property (i_reg_rd && i_reg_addr == `PDRS_OFS_DRIVER_ENABLE_STATUS |=> o_reg_rdata == $past(o_pin_oe))
        else $error("enable status wrong");
endmodule // pdrs_port_sva
bind pdrs_port pdrs_port_sva pdrs_port_sva_i (.i_clk, .i_rst_b, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_rvalid, .i_pin_in, .o_pin_oe, .i_cell_load, .o_output_logic_cell_q);
`default_nettype wire

/* File: bench/pdrs_host_model.sv */
// Processor core model issuing one-cycle register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module pdrs_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_wr,
    output logic o_rd,
    output logic [3:0] o_addr,
    output logic [7:0] o_wdata
);
    // The bus idles low so nothing is requested during reset.
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 4'h0;
        o_wdata = 8'h00;
    end
    // One write strobe; the lowering edge is never shared with a new request.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask
    // A missing answer returns unknowns so the caller's compare fails.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rvalid ? i_rdata : 8'hXX;
    endtask
endmodule // pdrs_host_model
`default_nettype wire

/* File: bench/port_data_register_set_bench.sv */
// Self-checking bench for one general-purpose port.
`timescale 1ns/1ps
`default_nettype none
module port_data_register_set_bench;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic wr, rd, rvalid, strobe = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, pin_out, pin_oe, slew, cell_q, in_q;
    logic [7:0] pin_in = 8'h00, logic_oe = 8'h00, cell_d = 8'h00, cell_load = 8'h00;
    logic [7:0] gate = 8'h00, addr_low = 8'h00, zero = 8'h00;
    logic [7:0] out_sel = 8'h00, nbr = 8'h00;
    int errors = 0;
    int samples_checked = 0;
    pdrs_host_model pdrs_host_model_i (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd),
        .o_addr(addr), .o_wdata(wdata));
    pdrs_port pdrs_port_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_pin_in(pin_in), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .o_fast_slew(slew), .i_logic_oe(logic_oe), .i_logic_out_sel(out_sel), .i_cell_d(cell_d),
        .i_cell_load(cell_load), .i_neighbour_cell_q(nbr), .o_output_logic_cell_q(cell_q),
        .i_input_cell_gate(gate), .i_input_cell_latch_mode(zero), .o_input_logic_cell_q(in_q),
        .i_addr_strobe(strobe), .i_addr_low(addr_low), .i_periph_data(zero), .i_periph_oe(zero));
    // Free-running system clock.
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        pdrs_host_model_i.rd(a, d);
        chk(d, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic t_reset();
        rd_chk(4'h6, 8'h00);
        rd_chk(4'h1, 8'h00);
        rd_chk(4'h8, 8'h00);
    endtask
    task automatic t_latch();
        pdrs_host_model_i.wr(4'h1, 8'h5A);
        rd_chk(4'h1, 8'h5A);
        pdrs_host_model_i.wr(4'h2, 8'h0F);
        settle(2);
        chk(pin_oe, 8'h0F);
        chk(pin_out & 8'h0F, 8'h0A);
        rd_chk(4'h8, 8'h0F);
        @(posedge i_clk);
        logic_oe <= 8'h10;
        settle(3);
        chk(pin_oe, 8'h1F);
        chk(pin_out & 8'h1F, 8'h1A);
        @(posedge i_clk);
        logic_oe <= 8'h00;
    endtask
    task automatic t_cells();
        pdrs_host_model_i.wr(4'h6, 8'h0F);
        rd_chk(4'h6, 8'h0F);
        pdrs_host_model_i.wr(4'h5, 8'hFF);
        rd_chk(4'h5, 8'hF0);
        pdrs_host_model_i.wr(4'h6, 8'h00);
        pdrs_host_model_i.wr(4'h5, 8'h3C);
        rd_chk(4'h5, 8'h3C);
        chk(cell_q, 8'h3C);
        pdrs_host_model_i.wr(4'h6, 8'hFF);
        cell_d <= 8'h81;
        cell_load <= 8'hFF;
        @(posedge i_clk);
        cell_load <= 8'h00;
        settle(1);
        chk(cell_q, 8'h81);
    endtask
    task automatic t_pins();
        @(posedge i_clk);
        pin_in <= 8'hA5;
        gate <= 8'hFF;
        settle(8);
        rd_chk(4'h0, 8'hA5);
        rd_chk(4'h7, 8'hA5);
        chk(in_q, 8'hA5);
        // Closed gates must hold the input cells while the pins move on.
        @(posedge i_clk);
        gate <= 8'h00;
        pin_in <= 8'h3C;
        settle(8);
        rd_chk(4'h0, 8'h3C);
        rd_chk(4'h7, 8'hA5);
        chk(in_q, 8'hA5);
    endtask
    // Shared cells reach the pins through the route bit; this port has no peripheral mode.
    task automatic t_route();
        pdrs_host_model_i.wr(4'h9, 8'h03);
        rd_chk(4'h9, 8'h01);
        @(posedge i_clk);
        nbr <= 8'h96;
        out_sel <= 8'hFF;
        settle(3);
        chk(pin_out, 8'h96);
        pdrs_host_model_i.wr(4'h9, 8'h00);
        settle(2);
        chk(pin_out, 8'h81);
        @(posedge i_clk);
        out_sel <= 8'h00;
        settle(2);
        chk(pin_out, 8'h5A);
    endtask
    task automatic t_addr();
        pdrs_host_model_i.wr(4'h3, 8'hFF);
        pdrs_host_model_i.wr(4'h2, 8'hFF);
        addr_low <= 8'hC3;
        strobe <= 1'b1;
        @(posedge i_clk);
        strobe <= 1'b0;
        settle(3);
        chk(pin_out, 8'hC3);
        chk(pin_oe, 8'hFF);
    endtask
    task automatic t_drive();
        pdrs_host_model_i.wr(4'h3, 8'h00);
        pdrs_host_model_i.wr(4'h1, 8'hF0);
        pdrs_host_model_i.wr(4'h4, 8'hFF);
        settle(3);
        chk(slew, 8'h0F);
        chk(pin_oe, 8'h0F);
        pdrs_host_model_i.wr(4'h8, 8'hFF);
        rd_chk(4'h8, 8'h0F);
        rd_chk(4'hF, 8'h00);
    endtask
    // Verdict and end of run, shared by the main sequence and the watchdog.
    task automatic close_out();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Reset for six cycles, then the scenarios in turn.
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_reset();
        t_latch();
        t_cells();
        t_pins();
        t_route();
        t_addr();
        t_drive();
        close_out();
    end
    // The scenarios need well under 300 cycles; a hang stops here.
    initial begin
        repeat (3000) @(posedge i_clk);
        errors++;
        close_out();
    end
endmodule // port_data_register_set_bench
`default_nettype wire
